/* rtl/octal_adc_serial_capture.sv */
// capture engine: four serial converter lines into a quad packet store
`timescale 1ns/1ns
// How it works
// - capture machine runs on the converter bit clock, apart from system clock
// - frame clock level is sampled by the capture machine every bit clock
// - four serial data lines, one per converter
// - machine has four states: left sync, right sync, capture, pause
// - sync states wait for frame alignment and a free packet buffer
// - once synced, capture and pause alternate; bytes written on capture only
// - capture and pause each last one bit clock; sync states wait as long as needed
// - alternation starts after frame clock falls, runs until stopped or all buffers full
// - all-full flag high when four buffers hold data, clears as sent
// - full during capture drops back to sync, discarding bits
// - restart only at frame edge so losses are whole frames
// - unregistered full condition blocks writes so unsent data is never overwritten
// - start and stop come from the control framework, not the machine
// - store is four buffers of 768 bytes each
// - buffer commits on its last byte and is sent on host request
// - one packet sent per microframe request
// - path sized to carry 3.072 MB/s without loss
// - delayed plus current bit gives two bits per line per byte
module octal_adc_serial_capture (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic bit_clk,
  input wire logic frame_clk,
  input wire logic [capture_pkg::NUM_LINES-1:0] adc_data,
  input wire logic ctrl_valid,
  input wire logic [7:0] ctrl_code,
  input wire logic pkt_req,
  output capture_pkg::tx_beat_s tx_beat,
  output logic recording,
  output logic buffers_all_full
);

  function automatic logic [capture_pkg::PTR_W-1:0] bin2gray(input logic [capture_pkg::PTR_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction : bin2gray

  function automatic logic [capture_pkg::PTR_W-1:0] gray2bin(input logic [capture_pkg::PTR_W-1:0] g);
    logic [capture_pkg::PTR_W-1:0] b;
    b[capture_pkg::PTR_W-1] = g[capture_pkg::PTR_W-1];
    for (int i = capture_pkg::PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction : gray2bin

  function automatic logic [capture_pkg::ADDR_W-1:0] store_addr(input logic [1:0] buf_sel,
                                                                input logic [capture_pkg::IDX_W-1:0] idx);
    store_addr = capture_pkg::ADDR_W'(buf_sel * capture_pkg::PKT_BYTES) + capture_pkg::ADDR_W'(idx);
  endfunction : store_addr

  logic [7:0] store [0:capture_pkg::NUM_BUFS*capture_pkg::PKT_BYTES-1];

  //////////////////////////////////////////////////////////////////////////////
  // system domain: control and send engine
  logic run_reg, run_next;
  logic [capture_pkg::PTR_W-1:0] rptr_reg, rptr_next;
  logic [capture_pkg::PTR_W-1:0] rgray_reg, rgray_next;
  logic sending_reg, sending_next;
  logic [capture_pkg::IDX_W-1:0] rd_idx_reg, rd_idx_next;
  logic [capture_pkg::PTR_W-1:0] wgray_reg;
  logic [capture_pkg::PTR_W-1:0] wgray_s1_reg, wgray_s2_reg;
  logic [capture_pkg::PTR_W-1:0] wptr_sys;
  capture_pkg::tx_beat_s tx_reg, tx_next;

  assign wptr_sys = gray2bin(wgray_s2_reg);

  always_comb begin
    run_next = run_reg;
    rptr_next = rptr_reg;
    sending_next = sending_reg;
    rd_idx_next = rd_idx_reg;
    tx_next = '0;
    // control framework owns start and stop
    if (ctrl_valid && ctrl_code == capture_pkg::START_CODE && !run_reg) begin
      run_next = 1'b1;
    end
    if (ctrl_valid && ctrl_code == capture_pkg::STOP_CODE) begin
      run_next = 1'b0;
      sending_next = 1'b0;
      rd_idx_next = '0;
      rptr_next = wptr_sys;
    end else if (sending_reg) begin
      tx_next.valid = 1'b1;
      tx_next.last = (rd_idx_reg == capture_pkg::LAST_IDX);
      tx_next.data = store[store_addr(rptr_reg[1:0], rd_idx_reg)];
      rd_idx_next = rd_idx_reg + 1'b1;
      if (rd_idx_reg == capture_pkg::LAST_IDX) begin
        sending_next = 1'b0;
        rd_idx_next = '0;
        rptr_next = rptr_reg + 1'b1;
      end
    end else if (pkt_req && rptr_reg != wptr_sys) begin
      sending_next = 1'b1;
    end
    rgray_next = bin2gray(rptr_next);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      run_reg <= 1'b0;
      rptr_reg <= capture_pkg::PTR_RESET;
      rgray_reg <= capture_pkg::PTR_RESET;
      sending_reg <= 1'b0;
      rd_idx_reg <= '0;
      tx_reg <= '0;
      wgray_s1_reg <= capture_pkg::PTR_RESET;
      wgray_s2_reg <= capture_pkg::PTR_RESET;
    end else begin
      run_reg <= run_next;
      rptr_reg <= rptr_next;
      rgray_reg <= rgray_next;
      sending_reg <= sending_next;
      rd_idx_reg <= rd_idx_next;
      tx_reg <= tx_next;
      wgray_s1_reg <= wgray_reg;
      wgray_s2_reg <= wgray_s1_reg;
    end
  end

  assign tx_beat = tx_reg;
  assign recording = run_reg;

  //////////////////////////////////////////////////////////////////////////////
  // bit clock domain: capture machine
  // four state machine
  capture_pkg::cap_state_e state_reg, state_next;
  logic [capture_pkg::PTR_W-1:0] wptr_reg, wptr_next;
  logic [capture_pkg::IDX_W-1:0] wr_idx_reg, wr_idx_next;
  logic [capture_pkg::NUM_LINES-1:0] dly_reg;
  logic run_s1_reg, run_s2_reg;
  logic [capture_pkg::PTR_W-1:0] rgray_s1_reg, rgray_s2_reg;
  logic [capture_pkg::PTR_W-1:0] rptr_link;
  logic full_c;
  logic full_reg;
  logic wr_en;
  logic [7:0] wr_byte;

  assign rptr_link = gray2bin(rgray_s2_reg);
  // four buffers filled and not yet sent
  assign full_c = (wptr_reg[2] != rptr_link[2]) && (wptr_reg[1:0] == rptr_link[1:0]);

  always_comb begin
    // line 0 pair in the top bits
    // delayed bit then current bit per line
    for (int i = 0; i < capture_pkg::NUM_LINES; i++) begin
      wr_byte[7-2*i] = dly_reg[i];
      wr_byte[6-2*i] = adc_data[i];
    end
  end

  always_comb begin
    state_next = state_reg;
    wptr_next = wptr_reg;
    wr_idx_next = wr_idx_reg;
    wr_en = 1'b0;
    case (state_reg)
      // wait for free buffer and frame clock high
      // frame clock level read each bit clock
      capture_pkg::LEFT_FRAME_SYNC_STATE: begin
        if (run_s2_reg && !full_c && frame_clk) begin
          state_next = capture_pkg::RIGHT_FRAME_SYNC_STATE;
        end
      end
      capture_pkg::RIGHT_FRAME_SYNC_STATE: begin
        if (!run_s2_reg || full_c) begin
          state_next = capture_pkg::LEFT_FRAME_SYNC_STATE;
        end else if (!frame_clk) begin
          state_next = capture_pkg::CAPTURE_STATE;
        end
      end
      capture_pkg::CAPTURE_STATE: begin
        if (!run_s2_reg || full_c) begin
          state_next = capture_pkg::LEFT_FRAME_SYNC_STATE;
        end else begin
          wr_en = 1'b1;
          wr_idx_next = wr_idx_reg + 1'b1;
          state_next = capture_pkg::PAUSE_STATE;
          if (wr_idx_reg == capture_pkg::LAST_IDX) begin
            wr_idx_next = '0;
            wptr_next = wptr_reg + 1'b1;
          end
        end
      end
      capture_pkg::PAUSE_STATE: begin
        if (!run_s2_reg || full_c) begin
          state_next = capture_pkg::LEFT_FRAME_SYNC_STATE;
        end else begin
          state_next = capture_pkg::CAPTURE_STATE;
        end
      end
      default: state_next = capture_pkg::LEFT_FRAME_SYNC_STATE;
    endcase
    if (!run_s2_reg) begin
      wr_idx_next = '0;
    end
  end

  // whole machine on the bit clock
  always_ff @(posedge bit_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= capture_pkg::LEFT_FRAME_SYNC_STATE;
      wptr_reg <= capture_pkg::PTR_RESET;
      wgray_reg <= capture_pkg::PTR_RESET;
      wr_idx_reg <= '0;
      dly_reg <= '0;
      run_s1_reg <= 1'b0;
      run_s2_reg <= 1'b0;
      rgray_s1_reg <= capture_pkg::PTR_RESET;
      rgray_s2_reg <= capture_pkg::PTR_RESET;
      full_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      wptr_reg <= wptr_next;
      wgray_reg <= bin2gray(wptr_next);
      wr_idx_reg <= wr_idx_next;
      dly_reg <= adc_data;
      run_s1_reg <= run_reg;
      run_s2_reg <= run_s1_reg;
      rgray_s1_reg <= rgray_reg;
      rgray_s2_reg <= rgray_s1_reg;
      full_reg <= full_c;
    end
  end

  always_ff @(posedge bit_clk) begin
    if (wr_en) begin
      store[store_addr(wptr_reg[1:0], wr_idx_reg)] <= wr_byte;
    end
  end

  assign buffers_all_full = full_reg;

  //////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_frame_fall;
    state_reg == capture_pkg::RIGHT_FRAME_SYNC_STATE && !frame_clk && run_s2_reg && !full_c;
  endsequence
  sequence s_running;
    run_s2_reg && !full_c;
  endsequence

  property p_start_on_fall;
    @(posedge bit_clk) disable iff (!rst_n) s_frame_fall |=> state_reg == capture_pkg::CAPTURE_STATE;
  endproperty
  a_start_on_fall: assert property (p_start_on_fall) else $error("capture did not follow frame fall");

  property p_alternate;
    @(posedge bit_clk) disable iff (!rst_n)
      (state_reg == capture_pkg::CAPTURE_STATE && run_s2_reg && !full_c) ##1 s_running
      |=> state_reg == capture_pkg::CAPTURE_STATE;
  endproperty
  a_alternate: assert property (p_alternate) else $error("capture and pause did not alternate");

  property p_full_abort;
    @(posedge bit_clk) disable iff (!rst_n)
      (state_reg inside {capture_pkg::CAPTURE_STATE, capture_pkg::PAUSE_STATE}) && full_c
      |=> state_reg == capture_pkg::LEFT_FRAME_SYNC_STATE;
  endproperty
  a_full_abort: assert property (p_full_abort) else $error("overflow did not return to sync");

  property p_no_write_full;
    @(posedge bit_clk) disable iff (!rst_n) wr_en |-> !full_c && state_reg == capture_pkg::CAPTURE_STATE;
  endproperty
  a_no_write_full: assert property (p_no_write_full) else $error("write while full or outside capture");

  property p_commit;
    @(posedge bit_clk) disable iff (!rst_n)
      wr_en && wr_idx_reg == capture_pkg::LAST_IDX |=> wptr_reg == $past(wptr_reg) + 3'h1 && wr_idx_reg == '0;
  endproperty
  a_commit: assert property (p_commit) else $error("last byte did not commit buffer");

  property p_stopped_idle;
    @(posedge bit_clk) disable iff (!rst_n)
      !run_s2_reg [*2] |-> state_reg == capture_pkg::LEFT_FRAME_SYNC_STATE && !wr_en;
  endproperty
  a_stopped_idle: assert property (p_stopped_idle) else $error("machine active while stopped");

  property p_full_flag;
    @(posedge bit_clk) disable iff (!rst_n) full_c |=> buffers_all_full;
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("all full flag not raised");

  property p_packet_len;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(tx_reg.valid) && !(ctrl_valid && ctrl_code == capture_pkg::STOP_CODE) |-> tx_reg.valid [*2];
  endproperty
  a_packet_len: assert property (p_packet_len) else $error("packet send cut short");

  property p_last_beat;
    @(posedge clk_sys) disable iff (!rst_n) tx_reg.last |-> tx_reg.valid ##1 !tx_reg.valid;
  endproperty
  a_last_beat: assert property (p_last_beat) else $error("last beat not final");

endmodule : octal_adc_serial_capture

/* rtl/capture_pkg.sv */
// shared constants and types for the octal converter capture engine
package capture_pkg;
  // packet store geometry
  localparam int NUM_BUFS = 4;
  localparam int PKT_BYTES = 768;
  localparam int NUM_LINES = 4;
  localparam int PTR_W = 3;
  localparam int IDX_W = 10;
  localparam int ADDR_W = 12;
  localparam logic [IDX_W-1:0] LAST_IDX = 10'h2FF;
  localparam logic [PTR_W-1:0] PTR_RESET = 3'h0;
  // vendor control codes
  localparam logic [7:0] START_CODE = 8'hB6;
  localparam logic [7:0] STOP_CODE = 8'hB7;
  // link figures
  localparam int MICROFRAMES_PER_SEC = 8000;
  localparam int BYTES_PER_SEC = 3072000;
  localparam int LINK_BYTES_PER_SEC = PKT_BYTES * MICROFRAMES_PER_SEC;

  typedef enum logic [1:0] {
    LEFT_FRAME_SYNC_STATE,
    RIGHT_FRAME_SYNC_STATE,
    CAPTURE_STATE,
    PAUSE_STATE
  } cap_state_e;

  typedef struct packed {
    logic valid;
    logic last;
    logic [7:0] data;
  } tx_beat_s;
endpackage : capture_pkg

/* tb/adc_quad_model.sv */
// four converters sharing one frame clock, one serial line each
`timescale 1ns/1ns
module adc_quad_model #(
  parameter int HALF_BITS = 32
) (
  input wire logic bit_clk,
  input wire logic [3:0] line_bits,
  output logic frame_clk,
  output logic [3:0] adc_data
);
  int slot = 0;
  initial begin
    frame_clk = 1'b1;
    adc_data = 4'h0;
  end
  ////////////////////////////////////////////////////////////
  // frame clock toggles each half
  always @(posedge bit_clk) begin
    slot <= (slot == 2 * HALF_BITS - 1) ? 0 : slot + 1;
    if (slot % HALF_BITS == HALF_BITS - 1) begin
      frame_clk <= #1 ~frame_clk;
    end
    adc_data <= #1 line_bits;
  end
endmodule : adc_quad_model

/* tb/testbench.sv */
// self-checking bench for the capture engine
`timescale 1ns/1ns
module testbench;
  logic clk_sys = 1'b0;
  logic bit_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ctrl_valid = 1'b0;
  logic pkt_req = 1'b0;
  logic [7:0] ctrl_code = 8'h00;
  logic [3:0] line_bits = 4'h0;
  logic [31:0] rnd = 32'h0240;
  logic frame_clk;
  logic [3:0] adc_data;
  logic [3:0] prev_bits = 4'h0;
  logic [7:0] b;
  capture_pkg::tx_beat_s tx_beat;
  logic recording;
  logic buffers_all_full;
  logic [7:0] exp_q[$];
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;
  int rx_bytes = 0;
  int st = 0;
  bit armed = 1'b0;

  always #5 clk_sys = ~clk_sys;
  initial begin
    #7;
    forever #80 bit_clk = ~bit_clk;
  end

  octal_adc_serial_capture dut (.clk_sys(clk_sys), .rst_n(rst_n), .bit_clk(bit_clk), .frame_clk(frame_clk),
    .adc_data(adc_data), .ctrl_valid(ctrl_valid), .ctrl_code(ctrl_code), .pkt_req(pkt_req), .tx_beat(tx_beat),
    .recording(recording), .buffers_all_full(buffers_all_full));
  adc_quad_model model (.bit_clk(bit_clk), .line_bits(line_bits), .frame_clk(frame_clk), .adc_data(adc_data));

  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] expv);
    total_checks++;
    if (seen !== expv) begin
      err_total++;
      $display("[ERR] %s expected %0h seen %0h", what, expv, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run

  task automatic ctrl(input logic [7:0] code, input logic want);
    @(posedge clk_sys) #1;
    ctrl_valid = 1'b1;
    ctrl_code = code;
    @(posedge clk_sys) #1;
    ctrl_valid = 1'b0;
    @(posedge clk_sys) #1;
    check("recording", {31'h0, recording}, {31'h0, want});
  endtask : ctrl

  task automatic request(input logic want);
    @(posedge clk_sys) #1;
    pkt_req = 1'b1;
    @(posedge clk_sys) #1;
    pkt_req = 1'b0;
    check("valid_early", {31'h0, tx_beat.valid}, 32'h0);
    @(posedge clk_sys) #1;
    check("valid_due", {31'h0, tx_beat.valid}, {31'h0, want});
  endtask : request

  ////////////////////////////////////////////////////////////
  // random serial data and reference capture machine
  always @(posedge bit_clk) begin
    #1;
    line_bits = rnd[3:0];
    rnd = xs(rnd);
  end

  always @(posedge bit_clk) begin
    if (armed) begin
      case (st)
        0: if (frame_clk) st = 1;
        1: if (!frame_clk) st = 2;
        2: begin
          for (int i = 0; i < 4; i++) b[7 - 2 * i -: 2] = {prev_bits[i], adc_data[i]};
          exp_q.push_back(b);
          st = 3;
        end
        default: st = 2;
      endcase
    end
    prev_bits = adc_data;
  end

  always @(negedge clk_sys) begin
    if (tx_beat.valid === 1'b1) begin
      rx_bytes++;
      check("queued", 32'(exp_q.size() > 0), 32'h1);
      check("tx_data", {24'h0, tx_beat.data}, {24'h0, exp_q.pop_front()});
      check("tx_last", {31'h0, tx_beat.last}, {31'h0, rx_bytes % 768 == 0});
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 80000) begin
      err_total++;
      complete_run();
    end
  end

  ////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge bit_clk);
    check("rst_rec", {31'h0, recording}, 32'h0);
    check("rst_full", {31'h0, buffers_all_full}, 32'h0);
    @(posedge clk_sys) #1;
    rst_n = 1'b1;
    ctrl({1'b0, rnd[6:0]}, 1'b0);
    request(1'b0);
    @(negedge frame_clk);
    armed = 1'b1;
    ctrl(capture_pkg::START_CODE, 1'b1);
    ctrl(capture_pkg::START_CODE, 1'b1);
    for (int p = 0; p < 2; p++) begin
      wait (exp_q.size() >= 776 && rx_bytes == 768 * p);
      request(1'b1);
      check("full_flag", {31'h0, buffers_all_full}, 32'h0);
    end
    wait (rx_bytes == 1536);
    armed = 1'b0;
    st = 0;
    ctrl(capture_pkg::STOP_CODE, 1'b0);
    exp_q.delete();
    repeat (400) @(posedge clk_sys);
    request(1'b0);
    repeat (2000) @(posedge clk_sys);
    check("rx_total", rx_bytes, 32'd1536);
    complete_run();
  end
endmodule : testbench
